// file: omw_core_model.sv
// behavioural core and oscillator partner of the operating-mode controller
`timescale 1ns/1ps

module omw_core_model #(
    parameter START = 5
) (
    // clock
    input wire pclk,
    // oscillator run requests
    input wire hs_osc_run_q,
    input wire ls_osc_run_q,
    // oscillator ready levels
    output logic hs_osc_ready = 1'b0,
    output logic ls_osc_ready = 1'b0,
    // core instruction pulses and watchdog overflow pulse
    output logic halt_exec = 1'b0,
    output logic clr_wdt_exec = 1'b0,
    output logic wdt_overflow = 1'b0
);
    int hs_cnt = 0; // cycles since high-speed start
    int ls_cnt = 0; // cycles since low-speed start
    // ready drops as soon as a source stops, returns only after START cycles
    always @(posedge pclk) begin
        hs_cnt <= !hs_osc_run_q ? 0 : (hs_cnt < START) ? hs_cnt + 1 : hs_cnt;
        ls_cnt <= !ls_osc_run_q ? 0 : (ls_cnt < START) ? ls_cnt + 1 : ls_cnt;
        hs_osc_ready <= hs_osc_run_q && hs_cnt == START;
        ls_osc_ready <= ls_osc_run_q && ls_cnt == START;
    end
    // one-cycle pulse: 0 halt, 1 clear watchdog, 2 watchdog overflow
    task fire(input int kind);
        @(posedge pclk);
        halt_exec <= (kind == 0);
        clr_wdt_exec <= (kind == 1);
        wdt_overflow <= (kind == 2);
        @(posedge pclk);
        {halt_exec, clr_wdt_exec, wdt_overflow} <= 3'h0;
    endtask
endmodule

// file: omw_ctrl.v
// operating-mode and wake-up controller with apb register access
//
// Contract
// - select code 111 runs system from low-speed clock
// - slow switch waits for low-speed oscillator stable
// - codes 000-110 pick high-speed divided 1..64
// - fast switch waits for high-speed stable flag
// - halt with keeps 00 enters sleep
// - halt with keeps 01 enters low-speed-only idle
// - halt with keeps 11 enters both-clocks idle
// - halt with keeps 10 enters high-speed-only idle
// - execution stops at halt, state retained
// - halt sets power-down, clears time-out flag
// - halt clears the watchdog counter
// - wake on pin edge, interrupt or overflow
// - power-down cleared only by reset or clear-watchdog
// - overflow wake sets time-out, resets pc and sp
// - per-pin wake enable, falling edge only
// - pin wake resumes after the halt
// - disabled or stack-full interrupt resumes, stays pending
// - enabled interrupt with free stack takes entry
// - request already set at halt cannot wake
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "omw_map.vh"

module omw_ctrl #(
    parameter PA_W = 8,
    parameter NINT = 4
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_q,
    output reg pready_q,
    output reg pslverr_q,
    // processor core, same clock
    input wire halt_exec,
    input wire clr_wdt_exec,
    input wire [NINT-1:0] int_req,
    input wire [NINT-1:0] int_enable,
    input wire stack_full,
    // watchdog, same clock
    input wire wdt_overflow,
    // asynchronous pins and oscillator ready levels
    input wire [PA_W-1:0] porta_pin,
    input wire hs_osc_ready,
    input wire ls_osc_ready,
    // clock and power control
    output reg [2:0] sysclk_div_q,
    output reg sysclk_use_ls_q,
    output reg hs_osc_run_q,
    output reg ls_osc_run_q,
    output reg cpu_run_q,
    output reg [2:0] op_mode_q,
    // core event pulses
    output reg resume_after_halt_q,
    output reg int_entry_q,
    output reg pc_sp_reset_q,
    output reg wdt_clear_q,
    // status flags
    output reg power_down_flag_q,
    output reg watchdog_timeout_flag_q
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    reg [2:0] sysclk_select_q; // requested select code
    reg hs_osc_halt_keep_q; // keep high-speed running in halt
    reg ls_osc_halt_keep_q; // keep low-speed running in halt
    reg hs_osc_en_q; // software high-speed enable
    reg hs_osc_stable_flag_q; // high-speed stable, read only
    reg [PA_W-1:0] porta_wake_enable_q; // per-pin wake enable
    reg [PA_W-1:0] porta_prev_q; // last synchronised pin level
    reg [NINT-1:0] int_armed_q; // requests clear at halt
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [2:0] sysclk_div_d;
    reg hs_run_d;
    reg ls_run_d;
    wire [PA_W-1:0] porta_s; // synchronised pins
    wire [1:0] osc_rdy_s; // synchronised oscillator ready levels
    wire halted;
    wire halt_ok;
    wire [PA_W-1:0] pin_fall;
    wire pin_wake;
    wire [NINT-1:0] int_hit;
    wire int_wake;
    wire int_take;
    wire wdt_wake;
    wire wake;
    wire apb_setup;
    wire apb_wr;
    wire addr_ok;

    // ------------------------------------------------------------------------
    // synchronisers for pins and oscillator ready levels
    // ------------------------------------------------------------------------
    omw_sync #(
        .W(PA_W)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(porta_pin),
        .sync_q(porta_s)
    );

    omw_sync #(
        .W(2)
    ) u_osc_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({hs_osc_ready, ls_osc_ready}),
        .sync_q(osc_rdy_s)
    );

    // ------------------------------------------------------------------------
    // wake sources
    // ------------------------------------------------------------------------
    assign halted = state_q[2];
    // halt is accepted in any running state, including a pending switch
    assign halt_ok = halt_exec & ~halted;
    // only enabled pins, high-to-low transitions only
    assign pin_fall = porta_prev_q & ~porta_s & porta_wake_enable_q;
    assign pin_wake = |pin_fall;
    // a request already pending at halt time is masked out of wake-up
    assign int_hit = int_req & int_armed_q;
    assign int_wake = |int_hit;
    assign int_take = |(int_hit & int_enable) & ~stack_full;
    assign wdt_wake = wdt_overflow;
    assign wake = halted & (pin_wake | int_wake | wdt_wake);

    // ------------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------------
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pready_q & pwrite;
    assign addr_ok = (paddr == `OMW_ADDR_SCC) | (paddr == `OMW_ADDR_HS_OSC_CONTROL_REG) |
                     (paddr == `OMW_ADDR_STATUS) | (paddr == `OMW_ADDR_PORTA_WAKE_ENABLE);

    // ------------------------------------------------------------------------
    // next operating state and clock selection
    // ------------------------------------------------------------------------
    always @* begin
        state_d = state_q;
        sysclk_div_d = sysclk_div_q;
        case (state_q)
            `OMW_S_FAST: begin
                if (sysclk_select_q == `OMW_SEL_LS) begin
                    state_d = `OMW_S_TO_SLOW;
                end else begin
                    // divider change within the high-speed source is direct
                    sysclk_div_d = sysclk_select_q;
                end
            end
            `OMW_S_TO_SLOW: begin
                if (sysclk_select_q != `OMW_SEL_LS) begin
                    // withdrawn; go back through to-fast in case high-speed stopped
                    state_d = `OMW_S_TO_FAST;
                end else if (osc_rdy_s[0]) begin
                    state_d = `OMW_S_SLOW;
                    sysclk_div_d = `OMW_SEL_LS;
                end
            end
            `OMW_S_SLOW: begin
                if (sysclk_select_q != `OMW_SEL_LS) begin
                    state_d = `OMW_S_TO_FAST;
                end
            end
            `OMW_S_TO_FAST: begin
                if (sysclk_select_q == `OMW_SEL_LS) begin
                    state_d = `OMW_S_TO_SLOW;
                end else if (hs_osc_stable_flag_q) begin
                    // stays on the previous clock selection until the flag rises
                    state_d = `OMW_S_FAST;
                    sysclk_div_d = sysclk_select_q;
                end
            end
            default: begin
                // halted; leave through the transition states so that a
                // stopped oscillator is waited for before it is used again
                if (wake) begin
                    if (sysclk_div_q == `OMW_SEL_LS) begin
                        state_d = `OMW_S_TO_SLOW;
                    end else begin
                        state_d = `OMW_S_TO_FAST;
                    end
                end
            end
        endcase
        if (halt_ok) begin
            // keep bits taken on the very cycle of the halt
            case ({hs_osc_halt_keep_q, ls_osc_halt_keep_q})
                2'b00: state_d = `OMW_S_SLEEP;
                2'b01: state_d = `OMW_S_IDLE_LS_ONLY;
                2'b11: state_d = `OMW_S_IDLE_BOTH_CLOCKS;
                default: state_d = `OMW_S_IDLE_HS_ONLY;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // oscillator run requests per state
    // ------------------------------------------------------------------------
    always @* begin
        case (state_d)
            `OMW_S_SLEEP: begin
                hs_run_d = 1'b0;
                ls_run_d = 1'b0;
            end
            `OMW_S_IDLE_LS_ONLY: begin
                hs_run_d = 1'b0;
                ls_run_d = 1'b1;
            end
            `OMW_S_IDLE_BOTH_CLOCKS: begin
                hs_run_d = 1'b1;
                ls_run_d = 1'b1;
            end
            `OMW_S_IDLE_HS_ONLY: begin
                hs_run_d = 1'b1;
                ls_run_d = 1'b0;
            end
            `OMW_S_FAST, `OMW_S_TO_SLOW, `OMW_S_TO_FAST: begin
                // the high-speed source is forced on whenever it is needed
                hs_run_d = 1'b1;
                ls_run_d = 1'b1;
            end
            default: begin
                // in slow mode software may stop the high-speed source
                hs_run_d = hs_osc_en_q;
                ls_run_d = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // state, clock outputs and oscillator control
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= `OMW_S_FAST;
            sysclk_div_q <= `OMW_SEL_RST;
            sysclk_use_ls_q <= 1'b0;
            hs_osc_run_q <= 1'b1;
            ls_osc_run_q <= 1'b1;
            cpu_run_q <= 1'b1;
            op_mode_q <= `OMW_S_FAST;
            hs_osc_stable_flag_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_mode_q <= state_d;
            sysclk_div_q <= sysclk_div_d;
            sysclk_use_ls_q <= (sysclk_div_d == `OMW_SEL_LS);
            hs_osc_run_q <= hs_run_d;
            ls_osc_run_q <= ls_run_d;
            // execution frozen in every halted state; nothing else is touched
            cpu_run_q <= ~state_d[2];
            // flag drops while stopped and rises only once ready again
            hs_osc_stable_flag_q <= hs_osc_run_q & osc_rdy_s[1];
        end
    end

    // ------------------------------------------------------------------------
    // wake handling, watchdog clear and status flags
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            porta_prev_q <= {PA_W{1'b0}};
            int_armed_q <= {NINT{1'b0}};
            resume_after_halt_q <= 1'b0;
            int_entry_q <= 1'b0;
            pc_sp_reset_q <= 1'b0;
            wdt_clear_q <= 1'b0;
            power_down_flag_q <= 1'b0;
            watchdog_timeout_flag_q <= 1'b0;
        end else begin
            porta_prev_q <= porta_s;
            if (halt_ok) begin
                // arm only the requests that are clear at halt time
                int_armed_q <= ~int_req;
            end
            // the watchdog counts on by its own enable after this clear
            wdt_clear_q <= halt_ok;
            // overflow outranks an interrupt, interrupt outranks a pin
            pc_sp_reset_q <= wake & wdt_wake;
            int_entry_q <= wake & ~wdt_wake & int_wake & int_take;
            // pending interrupt stays in the core's request flag
            resume_after_halt_q <= wake & ~wdt_wake & ((int_wake & ~int_take) |
                                   (~int_wake & pin_wake));
            // set wins over a clear in the same cycle
            if (halt_ok) begin
                power_down_flag_q <= 1'b1;
            end else if (clr_wdt_exec) begin
                power_down_flag_q <= 1'b0;
            end
            if (wake & wdt_wake) begin
                watchdog_timeout_flag_q <= 1'b1;
            end else if (halt_ok) begin
                watchdog_timeout_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // apb registers: one wait-free access cycle after each setup cycle
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            sysclk_select_q <= `OMW_SEL_RST;
            hs_osc_halt_keep_q <= 1'b0;
            ls_osc_halt_keep_q <= 1'b0;
            hs_osc_en_q <= `OMW_HS_EN_RST;
            porta_wake_enable_q <= {PA_W{1'b0}};
        end else begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup & ~addr_ok;
            if (apb_setup & ~pwrite) begin
                // read data captured in setup, stable over the access cycle
                prdata_q <= 32'h0000_0000;
                if (paddr == `OMW_ADDR_SCC) begin
                    prdata_q[`OMW_SCC_SEL_HI:`OMW_SCC_SEL_LO] <= sysclk_select_q;
                    prdata_q[`OMW_SCC_HS_KEEP] <= hs_osc_halt_keep_q;
                    prdata_q[`OMW_SCC_LS_KEEP] <= ls_osc_halt_keep_q;
                end else if (paddr == `OMW_ADDR_HS_OSC_CONTROL_REG) begin
                    prdata_q[`OMW_HS_OSC_CONTROL_REG_FLAG] <= hs_osc_stable_flag_q;
                    prdata_q[`OMW_HS_OSC_CONTROL_REG_EN] <= hs_osc_en_q;
                end else if (paddr == `OMW_ADDR_STATUS) begin
                    prdata_q[`OMW_ST_PDF] <= power_down_flag_q;
                    prdata_q[`OMW_ST_TO] <= watchdog_timeout_flag_q;
                    prdata_q[`OMW_ST_MODE_HI:`OMW_ST_MODE_LO] <= state_q;
                    prdata_q[`OMW_ST_ACT_HI:`OMW_ST_ACT_LO] <= sysclk_div_q;
                end else if (paddr == `OMW_ADDR_PORTA_WAKE_ENABLE) begin
                    prdata_q[PA_W-1:0] <= porta_wake_enable_q;
                end
            end
            if (apb_wr) begin
                // status is read only; unmapped writes are dropped
                if (paddr == `OMW_ADDR_SCC) begin
                    sysclk_select_q <= pwdata[`OMW_SCC_SEL_HI:`OMW_SCC_SEL_LO];
                    hs_osc_halt_keep_q <= pwdata[`OMW_SCC_HS_KEEP];
                    ls_osc_halt_keep_q <= pwdata[`OMW_SCC_LS_KEEP];
                end else if (paddr == `OMW_ADDR_HS_OSC_CONTROL_REG) begin
                    hs_osc_en_q <= pwdata[`OMW_HS_OSC_CONTROL_REG_EN];
                end else if (paddr == `OMW_ADDR_PORTA_WAKE_ENABLE) begin
                    porta_wake_enable_q <= pwdata[PA_W-1:0];
                end
            end
        end
    end

endmodule

// file: omw_ctrl_sva.sv
// concurrent checks on the ports of the operating-mode controller
`timescale 1ns/1ps
`include "omw_map.vh"

module omw_ctrl_sva (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // core and oscillator inputs
    input wire halt_exec,
    input wire clr_wdt_exec,
    input wire wdt_overflow,
    input wire hs_osc_ready,
    input wire ls_osc_ready,
    // controller outputs
    input wire [2:0] sysclk_div_q,
    input wire sysclk_use_ls_q,
    input wire hs_osc_run_q,
    input wire ls_osc_run_q,
    input wire cpu_run_q,
    input wire [2:0] op_mode_q,
    input wire resume_after_halt_q,
    input wire pc_sp_reset_q,
    input wire wdt_clear_q,
    input wire power_down_flag_q,
    input wire watchdog_timeout_flag_q
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire halt_ok = halt_exec && cpu_run_q; // halt only counts while running
    // ready low long enough that no stale synchroniser value remains
    sequence hs_quiet_s; !hs_osc_ready [*3]; endsequence
    sequence ls_quiet_s; !ls_osc_ready [*3]; endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    halt_flags_a: assert property (halt_ok |=> power_down_flag_q && !watchdog_timeout_flag_q)
        else $error("halt left the flags wrong");
    wdt_clear_a: assert property (halt_ok |=> wdt_clear_q)
        else $error("halt did not clear the watchdog");
    halt_stop_a: assert property (halt_ok |=> !cpu_run_q && op_mode_q[2])
        else $error("halt did not stop execution");
    sleep_osc_a: assert property (op_mode_q == `OMW_S_SLEEP |-> !hs_osc_run_q && !ls_osc_run_q)
        else $error("oscillator running in sleep");
    idle_ls_a: assert property (op_mode_q == `OMW_S_IDLE_LS_ONLY |-> !hs_osc_run_q && ls_osc_run_q)
        else $error("wrong oscillators in low-speed idle");
    idle_both_a: assert property (op_mode_q == `OMW_S_IDLE_BOTH_CLOCKS |-> hs_osc_run_q && ls_osc_run_q)
        else $error("wrong oscillators in both-clock idle");
    idle_hs_a: assert property (op_mode_q == `OMW_S_IDLE_HS_ONLY |-> hs_osc_run_q && !ls_osc_run_q)
        else $error("wrong oscillators in high-speed idle");
    pdf_hold_a: assert property ($fell(power_down_flag_q) |-> $past(clr_wdt_exec))
        else $error("power-down flag cleared without clear-watchdog");
    ovf_wake_a: assert property (wdt_overflow && op_mode_q[2] |=>
            pc_sp_reset_q && watchdog_timeout_flag_q && power_down_flag_q && cpu_run_q)
        else $error("overflow wake handled wrongly");
    slow_clock_a: assert property (op_mode_q == `OMW_S_SLOW |-> sysclk_use_ls_q && sysclk_div_q == 3'h7)
        else $error("slow mode not on low-speed clock");
    fast_clock_a: assert property (op_mode_q == `OMW_S_FAST |-> !sysclk_use_ls_q && sysclk_div_q != 3'h7)
        else $error("fast mode on low-speed clock");
    hs_wait_a: assert property (hs_quiet_s ##0 op_mode_q == `OMW_S_TO_FAST |=> op_mode_q != `OMW_S_FAST)
        else $error("fast mode before high-speed stable");
    ls_wait_a: assert property (ls_quiet_s ##0 op_mode_q == `OMW_S_TO_SLOW |=> op_mode_q != `OMW_S_SLOW)
        else $error("slow mode before low-speed stable");
    pin_resume_a: assert property (resume_after_halt_q |-> cpu_run_q && $past(op_mode_q[2]))
        else $error("resume pulse outside a wake");
endmodule

bind omw_ctrl omw_ctrl_sva chk_i (.*);

// file: omw_map.vh
// register map, field layout, reset values and state codes of the operating-mode controller
`ifndef OMW_MAP_VH
`define OMW_MAP_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define OMW_ADDR_SCC 12'h000
`define OMW_ADDR_HS_OSC_CONTROL_REG 12'h004
`define OMW_ADDR_STATUS 12'h008
`define OMW_ADDR_PORTA_WAKE_ENABLE 12'h00C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define OMW_SCC_SEL_HI 7
`define OMW_SCC_SEL_LO 5
`define OMW_SCC_HS_KEEP 1
`define OMW_SCC_LS_KEEP 0
`define OMW_HS_OSC_CONTROL_REG_FLAG 1
`define OMW_HS_OSC_CONTROL_REG_EN 0
`define OMW_ST_PDF 0
`define OMW_ST_TO 1
`define OMW_ST_MODE_HI 4
`define OMW_ST_MODE_LO 2
`define OMW_ST_ACT_HI 7
`define OMW_ST_ACT_LO 5

// ----------------------------------------------------------------------------
// reset values and clock select codes
// ----------------------------------------------------------------------------
`define OMW_SEL_RST 3'h2
`define OMW_SEL_LS 3'h7
`define OMW_HS_EN_RST 1'h1

// ----------------------------------------------------------------------------
// operating states
// ----------------------------------------------------------------------------
`define OMW_S_FAST 3'h0
`define OMW_S_TO_SLOW 3'h1
`define OMW_S_SLOW 3'h2
`define OMW_S_TO_FAST 3'h3
`define OMW_S_SLEEP 3'h4
`define OMW_S_IDLE_LS_ONLY 3'h5
`define OMW_S_IDLE_BOTH_CLOCKS 3'h6
`define OMW_S_IDLE_HS_ONLY 3'h7

`endif

// file: omw_sync.v
// two-flip-flop synchroniser for a bundle of independent level signals
`timescale 1ns/1ps

module omw_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // asynchronous levels in, synchronous levels out
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_q
);

    reg [W-1:0] meta_q; // first stage, read only by the second stage

    // ------------------------------------------------------------------------
    // two stages; bits are independent, so no bus coherency is implied
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule

// file: tb_operating_mode_and_wakeup_ctrl.sv
// self-checking testbench of the operating-mode controller
`timescale 1ns/1ps
`include "omw_map.vh"

module tb_operating_mode_and_wakeup_ctrl;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] int_req = 4'h0;
    logic [3:0] int_enable = 4'h0;
    logic stack_full = 1'b0;
    logic [7:0] porta_pin = 8'hFF;
    wire [31:0] prdata_q;
    wire [2:0] sysclk_div_q, op_mode_q;
    wire halt_exec, clr_wdt_exec, wdt_overflow, hs_osc_ready, ls_osc_ready;
    wire pready_q, pslverr_q, sysclk_use_ls_q, hs_osc_run_q, ls_osc_run_q, cpu_run_q;
    wire resume_after_halt_q, int_entry_q, pc_sp_reset_q, wdt_clear_q;
    wire power_down_flag_q, watchdog_timeout_flag_q;
    int error_cnt = 0;
    int tests_run = 0;
    int n_res = 0, n_int = 0, n_pcsp = 0, n_clr = 0; // event pulse tallies
    logic [31:0] rd; // last read data
    logic err; // last error response
    logic [2:0] mode_exp [4] = '{`OMW_S_SLEEP, `OMW_S_IDLE_LS_ONLY, `OMW_S_IDLE_HS_ONLY, `OMW_S_IDLE_BOTH_CLOCKS};

    omw_ctrl #(.PA_W(8), .NINT(4)) uut (.*);
    omw_core_model #(.START(5)) core (.*);

    // ------------------------------------------------------------
    // clock, pulse tallies, tasks
    // ------------------------------------------------------------
    initial begin
        forever #10 pclk = ~pclk;
    end
    // pulses last one cycle, so tally them rather than poll
    always @(posedge pclk) begin
        n_res <= n_res + (resume_after_halt_q === 1'b1);
        n_int <= n_int + (int_entry_q === 1'b1);
        n_pcsp <= n_pcsp + (pc_sp_reset_q === 1'b1);
        n_clr <= n_clr + (wdt_clear_q === 1'b1);
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_cnt(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            error_cnt++;
            $display("Error at %0t: count %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; pready, data and error taken at the closing rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_q !== 1'b1 && n < 50);
        rd = prdata_q;
        err = pslverr_q;
        chk(32'(pready_q), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        while (op_mode_q !== m && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(op_mode_q), 32'(m));
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard, far beyond the run's length
    initial begin
        #400000;
        error_cnt++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        rd_chk(`OMW_ADDR_SCC, 32'h40);
        rd_chk(`OMW_ADDR_HS_OSC_CONTROL_REG, 32'h3);
        rd_chk(`OMW_ADDR_PORTA_WAKE_ENABLE, 32'h0);
        apb(1'b1, `OMW_ADDR_STATUS, 32'hFF);
        rd_chk(`OMW_ADDR_STATUS, 32'h40);
        rd_chk(12'h010, 32'h0);
        chk(32'(err), 32'h1);
        $display("test reset and map done");
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, `OMW_ADDR_SCC, 32'(i) << 5);
            repeat (2) @(posedge pclk);
            chk(32'(sysclk_div_q), 32'(i));
        end
        $display("test divider codes done");
        apb(1'b1, `OMW_ADDR_PORTA_WAKE_ENABLE, 32'h1);
        apb(1'b1, `OMW_ADDR_HS_OSC_CONTROL_REG, 32'h0);
        apb(1'b1, `OMW_ADDR_SCC, 32'hE2);
        wait_mode(`OMW_S_SLOW);
        chk({sysclk_use_ls_q, sysclk_div_q, hs_osc_run_q}, 32'h1E);
        core.fire(0);
        wait_mode(`OMW_S_IDLE_HS_ONLY);
        porta_pin <= 8'hFE;
        wait_mode(`OMW_S_TO_SLOW);
        wait_mode(`OMW_S_SLOW);
        chk_cnt(n_res, 1);
        porta_pin <= 8'hFF;
        apb(1'b1, `OMW_ADDR_SCC, 32'h0);
        wait_mode(`OMW_S_TO_FAST);
        wait_mode(`OMW_S_FAST);
        rd_chk(`OMW_ADDR_HS_OSC_CONTROL_REG, 32'h2);
        apb(1'b1, `OMW_ADDR_HS_OSC_CONTROL_REG, 32'h1);
        $display("test slow and fast switching done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `OMW_ADDR_SCC, 32'(k));
            int_req[0] <= (k == 3);
            int_enable <= (k == 3) ? 4'h7 : 4'h2;
            stack_full <= (k == 3);
            core.fire(0);
            repeat (2) @(posedge pclk);
            chk(32'(op_mode_q), 32'(mode_exp[k]));
            chk({hs_osc_run_q, ls_osc_run_q}, 32'(k));
            chk({cpu_run_q, power_down_flag_q, watchdog_timeout_flag_q}, 32'h2);
            if (k == 0)
                core.fire(2);
            else if (k == 1) begin
                porta_pin <= 8'hFD;
                repeat (8) @(posedge pclk);
                chk(32'(cpu_run_q), 32'h0);
                porta_pin <= 8'hFC;
            end else if (k == 2)
                int_req[1] <= 1'b1;
            else begin
                repeat (8) @(posedge pclk);
                chk(32'(cpu_run_q), 32'h0);
                int_req[2] <= 1'b1;
            end
            wait_mode(`OMW_S_FAST);
            if (k == 0)
                rd_chk(`OMW_ADDR_STATUS, 32'h3);
            chk(32'(power_down_flag_q), 32'h1);
            core.fire(1);
            repeat (2) @(posedge pclk);
            chk(32'(power_down_flag_q), 32'h0);
        end
        chk_cnt(n_pcsp, 1);
        chk_cnt(n_int, 1);
        chk_cnt(n_res, 3);
        chk_cnt(n_clr, 5);
        $display("test halt modes and wake sources done");
        print_verdict();
    end
endmodule
